// File: hdl/dmscp_regs.svh
// constants of the dual mode serial control port
`ifndef DMSCP_REGS_SVH
`define DMSCP_REGS_SVH

// four-level strap codes from the pad level detector
`define DMSCP_LVL_L 2'h0
`define DMSCP_LVL_R 2'h1
`define DMSCP_LVL_F 2'h2
`define DMSCP_LVL_H 2'h3

// smbus target address of strap pair L/L
`define DMSCP_SMB_ADDR_BASE 7'h3D
`define DMSCP_SMB_BYTE_BITS 4'h8
`define DMSCP_SMB_LAST_RBIT 4'h7
`define DMSCP_SMB_MAX_KHZ 400

// spi frame layout
`define DMSCP_SPI_FRAME_BITS 5'h11
`define DMSCP_SPI_RW_BIT 16
`define DMSCP_SPI_ADDR_MSB 15
`define DMSCP_SPI_ADDR_LSB 8
`define DMSCP_SPI_DATA_MSB 7

// register space
`define DMSCP_MUTE_REF_BASE 8'h10
`define DMSCP_MUTE_REF_COUNT 8
`define DMSCP_STATUS_ADDR 8'h20
`define DMSCP_MAPPED_TOP 8'h7F
`define DMSCP_UNMAPPED_VALUE 8'h00
`define DMSCP_REG_RESET 8'h00
`define DMSCP_MUTE_REF_RESET 8'h3F

// strap sampling delay after reset release
`define DMSCP_STRAP_SETTLE 2'h3

`endif

// File: hdl/dmscp_pkg.sv
// types of the dual mode serial control port
package dmscp_pkg;

  typedef enum logic [1:0] {
    DMSCP_MODE_NONE = 2'b00,
    DMSCP_MODE_SMBUS = 2'b01,
    DMSCP_MODE_SPI = 2'b10,
    DMSCP_MODE_SAVE = 2'b11
  } dmscp_mode_t;

  typedef enum logic [2:0] {
    DMSCP_SMB_IDLE = 3'b000,
    DMSCP_SMB_ADDR = 3'b001,
    DMSCP_SMB_REG = 3'b010,
    DMSCP_SMB_WDATA = 3'b011,
    DMSCP_SMB_ACK = 3'b100,
    DMSCP_SMB_RDATA = 3'b101,
    DMSCP_SMB_MACK = 3'b110
  } dmscp_smb_state_t;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [5:0] strap1;
    logic [5:0] strap2;
    logic [1:0] settle;
    logic strap_done;
    dmscp_mode_t mode;
    logic [6:0] target;
    dmscp_smb_state_t smb;
    dmscp_smb_state_t after;
    logic [3:0] bits;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic sda_low;
    logic [16:0] sr;
    logic [4:0] spi_cnt;
    logic mute;
  } dmscp_state_t;

  typedef struct packed {
    logic [127:0][7:0] mem;
  } dmscp_regs_t;

endpackage

// File: hdl/dmscp_reg_if.sv
// register access signals between port logic and register file
`timescale 1ns/1ps
interface dmscp_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [2:0] rate_sel;
  logic [7:0] mute_ref;
  logic [7:0] status;

  modport ctrl (
    output wr_en,
    output addr,
    output wdata,
    output rate_sel,
    output status,
    input rdata,
    input mute_ref
  );

  modport regs (
    input wr_en,
    input addr,
    input wdata,
    input rate_sel,
    input status,
    output rdata,
    output mute_ref
  );
endinterface

// File: hdl/dmscp_regfile.sv
// 8-bit register file behind the serial control port
`timescale 1ns/1ps
`include "dmscp_regs.svh"
module dmscp_regfile (
  input wire logic core_clk,
  input wire logic reset_n,
  dmscp_reg_if.regs rif
);
  import dmscp_pkg::*;

  dmscp_regs_t r;
  dmscp_regs_t next_r;
  logic [7:0] ref_addr;

  function automatic logic is_mapped(input logic [7:0] a);
    return a <= `DMSCP_MAPPED_TOP;
  endfunction

  always_comb begin
    next_r = r;
    // status byte is read only
    if (rif.wr_en && is_mapped(rif.addr) && rif.addr != `DMSCP_STATUS_ADDR) begin
      next_r.mem[rif.addr[6:0]] = rif.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      for (int i = 0; i < `DMSCP_MUTE_REF_COUNT; i++) begin
        r.mem[7'(`DMSCP_MUTE_REF_BASE) + 7'(i)] <= `DMSCP_MUTE_REF_RESET;
      end
    end else begin
      r <= next_r;
    end
  end

  // one threshold per data rate
  assign ref_addr = `DMSCP_MUTE_REF_BASE + {5'h00, rif.rate_sel};
  assign rif.mute_ref = r.mem[ref_addr[6:0]];
  // unmapped addresses answer a fixed byte
  assign rif.rdata = (rif.addr == `DMSCP_STATUS_ADDR) ? rif.status :
                     is_mapped(rif.addr) ? r.mem[rif.addr[6:0]] :
                     `DMSCP_UNMAPPED_VALUE;
endmodule // dmscp_regfile

// File: hdl/dmscp_top.sv
// dual mode smbus / spi register access port with mute threshold
//
// Summary of operation
// - mute when cable index exceeds rate threshold
// - mode strap: H save, F spi, R reserved, L smbus
// - mode fixed from strap sampled after each reset release
// - smbus uses shared pins, straps set address
// - smbus clock rates up to 400 kHz
// - address 0x3D plus strap a major, b minor
// - sda driven only as open-drain pulldown
// - nine clocks per byte, low ninth acknowledges
// - write: address, register, data, then store
// - read: register set, repeated start, byte returned
// - levels F and H use pins as spi
// - spi frame is 17 bits under chip select
// - chip select high ignores input, floats output
// - frame is direction, address, data, msb first
// - previous frame shifts out as new shifts in
// - spi write applied at chip select rise
// - input bits captured on rising clock edges
// - read frame loads data for next frame
// - daisy chain: 17 times N clocks per frame
`timescale 1ns/1ps
`include "dmscp_regs.svh"
module dmscp_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] mode_strap_level,
  input wire logic [1:0] target_addr_strap_a,
  input wire logic [1:0] target_addr_strap_b,
  input wire logic serial_clock_or_smbus_clock,
  input wire logic chip_select_or_strap_a,
  input wire logic serial_in_or_smbus_data,
  output logic serial_in_or_smbus_data_out,
  output logic serial_in_or_smbus_data_oe,
  output logic serial_out_or_strap_b,
  output logic serial_out_or_strap_b_oe,
  input wire logic [5:0] cable_length_index,
  input wire logic [2:0] data_rate_sel,
  output logic mute_outputs,
  output logic power_save,
  output logic mode_is_smbus,
  output logic mode_is_spi,
  output dmscp_pkg::dmscp_mode_t access_mode
);
  import dmscp_pkg::*;

  dmscp_state_t st;
  dmscp_state_t next_st;
  dmscp_reg_if rif ();
  logic wr_en;
  logic [7:0] wdata;
  logic spi_alive;
  logic clk_s;
  logic clk_rise;
  logic clk_fall;
  logic sda_s;
  logic cs_s;
  logic cs_rise;
  logic smb_start;
  logic smb_stop;

  function automatic dmscp_mode_t decode_mode(input logic [1:0] lvl);
    case (lvl)
      `DMSCP_LVL_H: decode_mode = DMSCP_MODE_SAVE;
      `DMSCP_LVL_F: decode_mode = DMSCP_MODE_SPI;
      `DMSCP_LVL_L: decode_mode = DMSCP_MODE_SMBUS;
      default: decode_mode = DMSCP_MODE_NONE;
    endcase
  endfunction

  function automatic logic [6:0] target_addr(input logic [1:0] a, input logic [1:0] b);
    target_addr = `DMSCP_SMB_ADDR_BASE + {3'h0, a, b};
  endfunction

  // pin view after the two synchroniser stages, bit order {cs, data, clk}
  assign clk_s = st.sync2[0];
  assign sda_s = st.sync2[1];
  assign cs_s = st.sync2[2];
  // 200 MHz sampling resolves every edge of a 400 kHz clock
  assign clk_rise = clk_s && !st.prev[0];
  assign clk_fall = !clk_s && st.prev[0];
  assign cs_rise = cs_s && !st.prev[2];
  assign smb_start = st.prev[0] && clk_s && st.prev[1] && !sda_s;
  assign smb_stop = st.prev[0] && clk_s && !st.prev[1] && sda_s;
  assign spi_alive = (st.mode == DMSCP_MODE_SPI) || (st.mode == DMSCP_MODE_SAVE);

  always_comb begin
    next_st = st;
    wr_en = 1'b0;
    wdata = st.shift;
    next_st.sync1 = {chip_select_or_strap_a, serial_in_or_smbus_data,
                     serial_clock_or_smbus_clock};
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    next_st.strap1 = {mode_strap_level, target_addr_strap_a, target_addr_strap_b};
    next_st.strap2 = st.strap1;

    // straps taken once after reset release, then frozen
    if (!st.strap_done) begin
      if (st.settle == `DMSCP_STRAP_SETTLE) begin
        next_st.strap_done = 1'b1;
        next_st.mode = decode_mode(st.strap2[5:4]);
        next_st.target = target_addr(st.strap2[3:2], st.strap2[1:0]);
      end else begin
        next_st.settle = st.settle + 2'h1;
      end
    end

    // smbus target
    if (st.mode == DMSCP_MODE_SMBUS) begin
      if (smb_start) begin
        // also serves as repeated start
        next_st.smb = DMSCP_SMB_ADDR;
        next_st.bits = 4'h0;
        next_st.sda_low = 1'b0;
      end else if (smb_stop) begin
        next_st.smb = DMSCP_SMB_IDLE;
        next_st.sda_low = 1'b0;
      end else begin
        case (st.smb)
          DMSCP_SMB_ADDR, DMSCP_SMB_REG, DMSCP_SMB_WDATA: begin
            if (clk_rise && st.bits < `DMSCP_SMB_BYTE_BITS) begin
              next_st.shift = {st.shift[6:0], sda_s};
              next_st.bits = st.bits + 4'h1;
            end else if (clk_fall && st.bits == `DMSCP_SMB_BYTE_BITS) begin
              next_st.bits = 4'h0;
              next_st.sda_low = 1'b1;
              next_st.smb = DMSCP_SMB_ACK;
              case (st.smb)
                DMSCP_SMB_ADDR: begin
                  // address in bits 7:1, direction in bit 0
                  if (st.shift[7:1] == st.target) begin
                    next_st.after = st.shift[0] ? DMSCP_SMB_RDATA : DMSCP_SMB_REG;
                  end else begin
                    next_st.sda_low = 1'b0;
                    next_st.smb = DMSCP_SMB_IDLE;
                  end
                end
                DMSCP_SMB_REG: begin
                  next_st.ptr = st.shift;
                  next_st.after = DMSCP_SMB_WDATA;
                end
                default: begin
                  wr_en = 1'b1;
                  next_st.after = DMSCP_SMB_WDATA;
                end
              endcase
            end
          end
          DMSCP_SMB_ACK: begin
            // end of the ninth pulse
            if (clk_fall) begin
              next_st.sda_low = 1'b0;
              next_st.smb = st.after;
              next_st.bits = 4'h0;
              if (st.after == DMSCP_SMB_RDATA) begin
                next_st.shift = rif.rdata;
                next_st.sda_low = !rif.rdata[7];
              end
            end
          end
          DMSCP_SMB_RDATA: begin
            if (clk_fall) begin
              if (st.bits == `DMSCP_SMB_LAST_RBIT) begin
                // transmitter lets go for the host acknowledge
                next_st.sda_low = 1'b0;
                next_st.smb = DMSCP_SMB_MACK;
              end else begin
                next_st.shift = {st.shift[6:0], 1'b0};
                next_st.sda_low = !st.shift[6];
                next_st.bits = st.bits + 4'h1;
              end
            end
          end
          DMSCP_SMB_MACK: begin
            if (clk_rise) begin
              if (sda_s) begin
                next_st.smb = DMSCP_SMB_IDLE;
              end else begin
                next_st.smb = DMSCP_SMB_ACK;
                next_st.after = DMSCP_SMB_RDATA;
              end
            end
          end
          default: begin
            next_st.sda_low = 1'b0;
          end
        endcase
      end
    end

    // spi peripheral: one 17-bit shift register
    if (spi_alive) begin
      if (!cs_s && clk_rise) begin
        next_st.sr = {st.sr[15:0], sda_s};
        if (st.spi_cnt < `DMSCP_SPI_FRAME_BITS) begin
          next_st.spi_cnt = st.spi_cnt + 5'h01;
        end
      end
      if (cs_rise) begin
        // in a chain the last 17 bits left in place are this device's
        if (st.spi_cnt == `DMSCP_SPI_FRAME_BITS) begin
          if (!st.sr[`DMSCP_SPI_RW_BIT]) begin
            wr_en = 1'b1;
          end else begin
            next_st.sr[`DMSCP_SPI_DATA_MSB:0] = rif.rdata;
          end
        end
        next_st.spi_cnt = 5'h00;
      end
      wdata = st.sr[`DMSCP_SPI_DATA_MSB:0];
    end

    next_st.mute = {2'h0, cable_length_index} > rif.mute_ref;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rif.wr_en = wr_en;
  assign rif.wdata = wdata;
  assign rif.addr = spi_alive ? st.sr[`DMSCP_SPI_ADDR_MSB:`DMSCP_SPI_ADDR_LSB] : st.ptr;
  assign rif.rate_sel = data_rate_sel;
  assign rif.status = {st.mute, power_save, cable_length_index};

  dmscp_regfile u_regfile (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .rif(rif)
  );

  // open-drain: only ever pulls low
  assign serial_in_or_smbus_data_out = 1'b0;
  assign serial_in_or_smbus_data_oe = (st.mode == DMSCP_MODE_SMBUS) && st.sda_low;
  assign serial_out_or_strap_b = st.sr[`DMSCP_SPI_RW_BIT];
  // enable follows the raw chip select pin without the clock
  assign serial_out_or_strap_b_oe = spi_alive && !chip_select_or_strap_a;
  assign mute_outputs = st.mute;
  assign power_save = (st.mode == DMSCP_MODE_SAVE);
  assign mode_is_smbus = (st.mode == DMSCP_MODE_SMBUS);
  assign mode_is_spi = spi_alive;
  assign access_mode = st.mode;
endmodule // dmscp_top

// File: testbench/dmscp_top_asserts.sv
// port assertions of the dual mode serial control port
`timescale 1ns/1ps
module dmscp_top_asserts (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic serial_clock_or_smbus_clock,
  input wire logic chip_select_or_strap_a,
  input wire logic serial_in_or_smbus_data_out,
  input wire logic serial_in_or_smbus_data_oe,
  input wire logic serial_out_or_strap_b,
  input wire logic serial_out_or_strap_b_oe,
  input wire logic [5:0] cable_length_index,
  input wire logic mute_outputs,
  input wire logic power_save,
  input wire logic mode_is_smbus,
  input wire logic mode_is_spi,
  input wire dmscp_pkg::dmscp_mode_t access_mode
);
  import dmscp_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  open_drain_a: assert property (
    serial_in_or_smbus_data_out == 1'b0) else $error("sda driven high");
  sda_mode_a: assert property (
    serial_in_or_smbus_data_oe |-> access_mode == DMSCP_MODE_SMBUS) else $error("sda outside smbus");
  sdo_enable_a: assert property (
    serial_out_or_strap_b_oe == (mode_is_spi && !chip_select_or_strap_a))
    else $error("sdo enable wrong");
  save_mode_a: assert property (
    power_save == (access_mode == DMSCP_MODE_SAVE)) else $error("power save wrong");
  spi_mode_a: assert property (
    mode_is_spi == (access_mode inside {DMSCP_MODE_SPI, DMSCP_MODE_SAVE}))
    else $error("spi flag wrong");
  smbus_mode_a: assert property (
    mode_is_smbus == (access_mode == DMSCP_MODE_SMBUS)) else $error("smbus flag wrong");
  mode_hold_a: assert property (
    access_mode != DMSCP_MODE_NONE |=> $stable(access_mode)) else $error("mode changed");
  ack_edge_a: assert property (
    $changed(serial_in_or_smbus_data_oe) |-> !serial_clock_or_smbus_clock)
    else $error("sda moved with scl high");
  sdo_idle_a: assert property (
    (mode_is_spi && chip_select_or_strap_a) [*6] |-> $stable(serial_out_or_strap_b))
    else $error("sdo shifted while idle");
  mute_cause_a: assert property (
    mute_outputs |-> $past(cable_length_index) != 6'h00) else $error("mute without cable");
endmodule // dmscp_top_asserts

bind dmscp_top dmscp_top_asserts chk (
  .core_clk, .reset_n, .serial_clock_or_smbus_clock, .chip_select_or_strap_a,
  .serial_in_or_smbus_data_out, .serial_in_or_smbus_data_oe, .serial_out_or_strap_b,
  .serial_out_or_strap_b_oe, .cable_length_index, .mute_outputs, .power_save,
  .mode_is_smbus, .mode_is_spi, .access_mode
);

// File: testbench/dmscp_host.sv
// host controller model for the smbus and spi pins
`timescale 1ns/1ps
module dmscp_host (
  input wire logic clk,
  input wire logic sda,
  input wire logic miso,
  output logic scl,
  output logic low,
  output logic cs_n
);
  localparam int Q = 170;
  initial begin
    scl = 1'b1;
    low = 1'b0;
    cs_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic sbit(input logic b, output logic r);
    low <= !b;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    r = sda;
    scl <= 1'b0;
    tick(Q);
  endtask
  task automatic sbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      sbit(d[i], r);
      q[i] = r;
    end
    sbit(1'b1, r);
    ack = !r;
  endtask
  task automatic start;
    low <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    low <= 1'b1;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask
  task automatic smb(input logic [6:0] ta, input logic [7:0] ra, input logic [7:0] wd,
                     input logic rd, output logic [7:0] q, output logic ok);
    logic a0, a1, a2, nk;
    start;
    sbyte({ta, 1'b0}, q, a0);
    sbyte(ra, q, a1);
    if (rd) begin
      start;
      sbyte({ta, 1'b1}, q, a2);
      sbyte(8'hFF, q, nk);
    end else begin
      sbyte(wd, q, a2);
    end
    low <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    low <= 1'b0;
    tick(Q);
    ok = a0 && a1 && a2;
  endtask
  task automatic spi(input logic [16:0] d, output logic [16:0] q);
    scl <= 1'b0;
    cs_n <= 1'b0;
    tick(8);
    for (int i = 16; i >= 0; i--) begin
      low <= !d[i];
      tick(16);
      q[i] = miso;
      scl <= 1'b1;
      tick(16);
      scl <= 1'b0;
    end
    tick(8);
    cs_n <= 1'b1;
    low <= d[0];
    tick(8);
  endtask
endmodule // dmscp_host

// File: testbench/tb_dual_mode_serial_control_port.sv
// self-checking bench of the dual mode serial control port
`timescale 1ns/1ps
`include "dmscp_regs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_dual_mode_serial_control_port;
  import dmscp_pkg::*;
  logic core_clk, reset_n, scl, low, cs_n, sda_o, sda_oe, sdo, sdo_oe, mute, psave;
  logic is_smb, is_spi, ok;
  logic [1:0] mode_lvl, strap_a, strap_b;
  logic [5:0] cable;
  logic [2:0] rate;
  logic [7:0] q8;
  logic [16:0] q17;
  dmscp_mode_t mode;
  int errors, checks_done;
  wire sda = !(low || (sda_oe && !sda_o));
  wire miso = sdo_oe ? sdo : 1'bz;
  dmscp_host host (.clk(core_clk), .sda(sda), .miso(miso), .scl(scl), .low(low), .cs_n(cs_n));
  dmscp_top dut (
    .core_clk(core_clk), .reset_n(reset_n), .mode_strap_level(mode_lvl),
    .target_addr_strap_a(strap_a), .target_addr_strap_b(strap_b),
    .serial_clock_or_smbus_clock(scl), .chip_select_or_strap_a(cs_n),
    .serial_in_or_smbus_data(sda), .serial_in_or_smbus_data_out(sda_o),
    .serial_in_or_smbus_data_oe(sda_oe), .serial_out_or_strap_b(sdo),
    .serial_out_or_strap_b_oe(sdo_oe), .cable_length_index(cable), .data_rate_sel(rate),
    .mute_outputs(mute), .power_save(psave), .mode_is_smbus(is_smb), .mode_is_spi(is_spi),
    .access_mode(mode)
  );
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = !core_clk;
  end
  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rst(input logic [1:0] m);
    @(posedge core_clk);
    reset_n <= 1'b0;
    mode_lvl <= m;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (12) @(posedge core_clk);
  endtask
  initial begin
    #500us;
    errors++;
    tally_and_finish;
  end
  initial begin
    reset_n = 1'b0;
    mode_lvl = `DMSCP_LVL_L;
    strap_a = `DMSCP_LVL_F;
    strap_b = `DMSCP_LVL_R;
    cable = 6'h3F;
    rate = 3'h0;
    rst(`DMSCP_LVL_L);
    `CHK("mode", DMSCP_MODE_SMBUS, mode)
    `CHK("smbus", 1'b1, is_smb)
    host.smb(7'h46, 8'h05, 8'hA5, 1'b0, q8, ok);
    `CHK("write ack", 1'b1, ok)
    host.smb(7'h45, 8'h05, 8'h00, 1'b0, q8, ok);
    `CHK("foreign ack", 1'b0, ok)
    host.smb(7'h46, 8'h05, 8'h00, 1'b1, q8, ok);
    `CHK("read 05", 8'hA5, q8)
    host.smb(7'h46, 8'h10, 8'h00, 1'b1, q8, ok);
    `CHK("read 10", `DMSCP_MUTE_REF_RESET, q8)
    `CHK("no mute", 1'b0, mute)
    rst(`DMSCP_LVL_F);
    `CHK("mode", DMSCP_MODE_SPI, mode)
    `CHK("sdo float", 1'b0, sdo_oe)
    host.spi({1'b0, 8'h03, 8'h5A}, q17);
    host.spi({1'b1, 8'h03, 8'hFF}, q17);
    `CHK("shift out", {1'b0, 8'h03, 8'h5A}, q17)
    host.spi({1'b1, 8'hFF, 8'hFF}, q17);
    `CHK("read 03", {1'b1, 8'h03, 8'h5A}, q17)
    host.spi({1'b0, 8'h13, 8'h20}, q17);
    `CHK("unmapped", {1'b1, 8'hFF, `DMSCP_UNMAPPED_VALUE}, q17)
    rate <= 3'h3;
    cable <= 6'h21;
    repeat (4) @(posedge core_clk);
    `CHK("mute", 1'b1, mute)
    cable <= 6'h20;
    repeat (4) @(posedge core_clk);
    `CHK("unmute", 1'b0, mute)
    rst(`DMSCP_LVL_H);
    `CHK("save", 1'b1, psave)
    `CHK("save spi", 1'b1, is_spi)
    host.spi({1'b0, 8'h07, 8'h77}, q17);
    host.spi({1'b1, 8'h07, 8'hFF}, q17);
    host.spi({1'b1, 8'hFF, 8'hFF}, q17);
    `CHK("save read", {1'b1, 8'h07, 8'h77}, q17)
    rst(`DMSCP_LVL_R);
    `CHK("reserved", DMSCP_MODE_NONE, mode)
    `CHK("reserved spi", 1'b0, is_spi)
    `CHK("reserved smbus", 1'b0, is_smb)
    tally_and_finish;
  end
endmodule // tb_dual_mode_serial_control_port
